// [test/host_model.sv]
`timescale 1ns/1ps
module host_model (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic polarity_rev_i,
  input wire logic data_ready_n_i,
  input wire logic [15:0] level_i,
  input wire logic [15:0] offset_i,
  input wire logic [1:0] read_lag_i,
  output chop_seq_pkg::conv_data_s conv_data_o,
  output logic result_read_o
);
  logic [1:0] lag;
  logic armed;
  logic data_ready_flag_q;
  // reversal flips the signal but not the front-end offset, so a chopped pair cancels it
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      if (polarity_rev_i) begin
        conv_data_o.ch[c] = offset_i - level_i - 16'(c);
      end else begin
        conv_data_o.ch[c] = level_i + 16'(c) + offset_i;
      end
    end
  end
  // only results are fetched, never the dc test signal
  // arm on the falling edge only, so one result is never read twice
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lag <= 2'h0;
      armed <= 1'b0;
      data_ready_flag_q <= 1'b1;
      result_read_o <= 1'b0;
    end else begin
      data_ready_flag_q <= data_ready_n_i;
      result_read_o <= 1'b0;
      if (data_ready_flag_q && !data_ready_n_i && !armed) begin
        armed <= 1'b1;
        lag <= read_lag_i;
      end else if (armed && lag != 2'h0) begin
        lag <= lag - 2'h1;
      end else if (armed) begin
        result_read_o <= 1'b1;
        armed <= 1'b0;
      end
    end
  end
endmodule

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
  localparam int MD = 2;
  localparam int RPC = 20;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic sync_reset_n_i = 1'b1;
  logic [15:0] level = 16'h0;
  logic [15:0] offset = 16'h0;
  logic [1:0] read_lag = 2'h0;
  chop_seq_pkg::conv_data_s conv_data;
  chop_seq_pkg::conv_data_s result_o;
  logic result_read;
  logic [31:0] rdata_o;
  logic mod_tick_o, filter_reset_o, polarity_rev_o, conv_end_o, data_ready_n_o;
  logic [1:0] power_level_o;
  logic standby_o, channel_enable_o, reference_enable_o, oscillator_enable_o, device_reset_o;
  integer seed = 32'h5a2d;
  int errors = 0;
  int n_compared = 0;
  int ends = 0;

  always #2 core_clk_i = ~core_clk_i;

  // conversion ends seen, to tie each data-ready fall to the conversions behind it
  always @(negedge core_clk_i) begin
    if (conv_end_o === 1'b1) ends++;
  end

  chop_sync_conversion_sequencer #(.MOD_DIV(MD), .RESET_PULSE_CYCLES(RPC)) dut_u (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sync_reset_n_i(sync_reset_n_i),
    .conv_data_i(conv_data), .result_read_i(result_read), .mod_tick_o(mod_tick_o),
    .filter_reset_o(filter_reset_o), .polarity_rev_o(polarity_rev_o),
    .conv_end_o(conv_end_o), .result_o(result_o), .data_ready_n_o(data_ready_n_o),
    .power_level_o(power_level_o), .standby_o(standby_o),
    .channel_enable_o(channel_enable_o), .reference_enable_o(reference_enable_o),
    .oscillator_enable_o(oscillator_enable_o), .device_reset_o(device_reset_o));

  host_model host_u (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .polarity_rev_i(polarity_rev_o),
    .data_ready_n_i(data_ready_n_o), .level_i(level), .offset_i(offset),
    .read_lag_i(read_lag), .conv_data_o(conv_data), .result_read_o(result_read));

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    @(negedge core_clk_i);
    d = rdata_o;
  endtask

  // pulse stays well under the reset threshold
  task automatic sync_pulse(input int len);
    @(posedge core_clk_i);
    sync_reset_n_i <= 1'b0;
    repeat (len) @(posedge core_clk_i);
    sync_reset_n_i <= 1'b1;
  endtask

  // cycles up to the next data-ready fall, with filter resets seen on the way
  task automatic wait_fall(output int n, output int fr);
    logic p;
    p = data_ready_n_o;
    n = 0;
    fr = 0;
    while (n < 4000) begin
      @(negedge core_clk_i);
      n++;
      if (filter_reset_o === 1'b1) fr++;
      if (p === 1'b1 && data_ready_n_o === 1'b0) return;
      p = data_ready_n_o;
    end
    errors++;
    $display("ERROR at %0t: no data ready fall", $time);
    stop_test();
  endtask

  function automatic int chop_t(input int code, input int oversampling_ratio);
    return (2 << code) + 3 * oversampling_ratio;
  endfunction

  function automatic int first_t(input int code, input int oversampling_ratio);
    return 2 * chop_t(code, oversampling_ratio) + 44;
  endfunction

  function automatic logic res_ok(input logic [15:0] base);
    logic ok;
    ok = 1'b1;
    for (int c = 0; c < 4; c++) begin
      if (result_o.ch[c] !== base + 16'(c)) ok = 1'b0;
    end
    return ok;
  endfunction

  initial begin
    int n;
    int fr;
    int f;
    logic [31:0] d;
    logic pol;
    int e0;
    level = 16'($random(seed)) & 16'h0fff;
    offset = 16'($random(seed)) & 16'h00fe;
    read_lag = 2'($random(seed));
    repeat (3) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    @(negedge core_clk_i);
    check({data_ready_n_o, power_level_o, standby_o}, 4'h8);
    rd(chop_seq_pkg::CTRL_OFFSET, d);
    check(d, 32'h0);
    rd(chop_seq_pkg::OSR_OFFSET, d);
    check(d, 32'h400);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, d);
    check(d, 32'h0);
    $display("test reset_values done");
    wr(chop_seq_pkg::OSR_OFFSET, 32'h8);
    wait_fall(n, fr);
    e0 = ends;
    wait_fall(n, fr);
    check(n, 8 * MD);
    check(ends - e0, 1);
    check({polarity_rev_o, res_ok(level + offset)}, 2'b01);
    repeat (5) @(negedge core_clk_i);
    fork
      sync_pulse(3);
      wait_fall(n, fr);
    join
    check(fr != 0, 1'b1);
    check(n >= 8 * MD && n <= 9 * MD + 6, 1'b1);
    $display("test continuous done");
    for (int p = 0; p < 3; p++) begin
      wr(chop_seq_pkg::CTRL_OFFSET, 32'(p) << 8);
      rd(chop_seq_pkg::CTRL_OFFSET, d);
      check({power_level_o, d[9:8]}, {2'(p), 2'(p)});
    end
    $display("test power_levels done");
    wr(chop_seq_pkg::OSR_OFFSET, 32'h4);
    for (int c = 0; c < 4; c++) begin
      wr(chop_seq_pkg::CTRL_OFFSET, (32'(c) << 1) | 32'h1);
      // a result finishing as the restart lands may still drop the flag, so step past it
      repeat (2) @(negedge core_clk_i);
      wait_fall(n, fr);
      n += 2;
      f = first_t(c, 4) * MD;
      check(n >= f && n <= f + MD + 8, 1'b1);
      pol = polarity_rev_o;
      check(res_ok(level), 1'b1);
      e0 = ends;
      wait_fall(n, fr);
      check(n, chop_t(c, 4) * MD);
      check(ends - e0, 1);
      check(fr, 1);
      check(polarity_rev_o !== pol, 1'b1);
      check(res_ok(level), 1'b1);
    end
    $display("test chop_delays done");
    wr(chop_seq_pkg::OSR_OFFSET, 32'h6);
    wait_fall(n, fr);
    f = first_t(3, 6) * MD;
    check(n >= f && n <= f + MD + 8, 1'b1);
    fork
      sync_pulse(3);
      wait_fall(n, fr);
    join
    check(fr != 0, 1'b1);
    check(n >= f && n <= f + MD + 8, 1'b1);
    $display("test chop_restart done");
    wr(chop_seq_pkg::CTRL_OFFSET, 32'h106);
    wr(chop_seq_pkg::CMD_OFFSET, 32'h1);
    repeat (2) @(negedge core_clk_i);
    check({standby_o, channel_enable_o, reference_enable_o, oscillator_enable_o}, 4'h8);
    n = 0;
    // core_clk_i keeps running, but in standby the modulator tick must stay low throughout
    repeat (8 * MD) begin
      @(negedge core_clk_i);
      if (mod_tick_o !== 1'b0) n++;
    end
    check(n, 0);
    rd(chop_seq_pkg::CTRL_OFFSET, d);
    check(d, 32'h106);
    wr(chop_seq_pkg::CMD_OFFSET, 32'h2);
    repeat (2) @(negedge core_clk_i);
    check({standby_o, channel_enable_o, reference_enable_o, oscillator_enable_o}, 4'h7);
    wait_fall(n, fr);
    rd(chop_seq_pkg::CTRL_OFFSET, d);
    check(d, 32'h106);
    $display("test standby done");
    @(posedge core_clk_i);
    sync_reset_n_i <= 1'b0;
    repeat (RPC + 4) @(posedge core_clk_i);
    wr(chop_seq_pkg::CTRL_OFFSET, 32'h1);
    @(negedge core_clk_i);
    check(device_reset_o, 1'b1);
    @(posedge core_clk_i);
    sync_reset_n_i <= 1'b1;
    repeat (3) @(negedge core_clk_i);
    check(device_reset_o, 1'b0);
    rd(chop_seq_pkg::CTRL_OFFSET, d);
    check(d, 32'h0);
    rd(chop_seq_pkg::OSR_OFFSET, d);
    check(d, 32'h400);
    $display("test pin_reset done");
    stop_test();
  end
endmodule

// [verilog/chop_seq_pkg.sv]
// Contract
// - chop mode alternates input polarity each conversion
// - result averages last two opposite-polarity conversions
// - filter reset on swap, three periods settle
// - programmable delay after swap, 2 to 65536
// - steady period is delay plus 3 x ratio
// - sync fall or ratio change restarts chop
// - first chop result: two periods plus 44
// - without chop, one result per ratio periods
// - three power levels from two-bit field
// - standby disables channels, reference, oscillator; keeps registers
// - wakeup command leaves standby, resumes conversion
// - aligned sync edge causes no action
// - misaligned sync edge resets filters, realigns
// - chop mode always restarts on sync edge
// - long low sync holds reset until high
// - continuous results flagged by data-ready fall
package chop_seq_pkg;
  localparam int unsigned NUM_CHANNELS = 4;
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned CORE_CLK_KHZ = 250000;
  localparam int unsigned MOD_CLK_KHZ = 8192;
  // divider rounds down, so the modulator rate sits slightly high
  localparam int unsigned MOD_DIV = CORE_CLK_KHZ / MOD_CLK_KHZ;
  localparam int unsigned CORE_CLK_MHZ = 250;
  localparam int unsigned RESET_PULSE_NS = 10000;
  localparam int unsigned RESET_PULSE_CYCLES = (RESET_PULSE_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned CHOP_SETTLE_EXTRA = 44;
  localparam int unsigned CHOP_FILTER_PASSES = 3;
  localparam int unsigned CHOP_DELAY_MIN = 2;

  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] OSR_OFFSET = 8'h04;
  localparam logic [7:0] CMD_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0c;

  localparam int unsigned CTRL_CHOP_EN_BIT = 0;
  localparam int unsigned CTRL_DLY_LSB = 1;
  localparam int unsigned CTRL_PWR_LSB = 8;
  localparam int unsigned CMD_STANDBY_BIT = 0;
  localparam int unsigned CMD_WAKEUP_BIT = 1;
  localparam int unsigned STAT_STANDBY_BIT = 0;
  localparam int unsigned STAT_POLARITY_BIT = 1;
  localparam int unsigned STAT_PENDING_BIT = 2;
  localparam int unsigned STAT_SETTLING_BIT = 3;

  typedef enum logic [1:0] {
    high_resolution_power = 2'h0,
    low_power_level = 2'h1,
    very_low_power_level = 2'h2
  } power_level_e;

  localparam logic CHOP_EN_RESET = 1'b0;
  localparam logic [3:0] DLY_CODE_RESET = 4'h0;
  localparam logic [1:0] PWR_RESET = 2'h0;
  localparam logic [15:0] OSR_RESET = 16'h0400;

  typedef struct packed {
    logic [1:0] power_level_select;
    logic [3:0] chop_delay_code;
    logic chop_enable;
  } ctrl_s;

  typedef struct packed {
    logic [NUM_CHANNELS-1:0][SAMPLE_W-1:0] ch;
  } conv_data_s;
endpackage

// [verilog/chop_sync_conversion_sequencer.sv]
`timescale 1ns/1ps
module chop_sync_conversion_sequencer #(
  parameter int unsigned MOD_DIV = chop_seq_pkg::MOD_DIV,
  parameter int unsigned RESET_PULSE_CYCLES = chop_seq_pkg::RESET_PULSE_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic sync_reset_n_i,
  input wire chop_seq_pkg::conv_data_s conv_data_i,
  input wire logic result_read_i,
  output logic mod_tick_o,
  output logic filter_reset_o,
  output logic polarity_rev_o,
  output logic conv_end_o,
  output chop_seq_pkg::conv_data_s result_o,
  output logic data_ready_n_o,
  output logic [1:0] power_level_o,
  output logic standby_o,
  output logic channel_enable_o,
  output logic reference_enable_o,
  output logic oscillator_enable_o,
  output logic device_reset_o
);
  typedef enum logic [1:0] {st_halt, st_settle, st_delay, st_conv} seq_state_e;

  function automatic logic [16:0] dly_ticks(input logic [3:0] code);
    dly_ticks = 17'(17'(chop_seq_pkg::CHOP_DELAY_MIN) << code);
  endfunction

  function automatic logic [18:0] conv_ticks(input logic chop, input logic [15:0] ratio);
    conv_ticks = chop ? 19'(19'(ratio) * 19'(chop_seq_pkg::CHOP_FILTER_PASSES)) : 19'(ratio);
  endfunction

  function automatic logic signed [16:0] oriented(input logic [15:0] x, input logic rev);
    oriented = rev ? -17'(signed'(x)) : 17'(signed'(x));
  endfunction

  chop_seq_pkg::ctrl_s ctrl;
  logic [15:0] oversampling_ratio;
  logic [$clog2(MOD_DIV+1)-1:0] div_cnt;
  logic [$clog2(RESET_PULSE_CYCLES+1)-1:0] low_cnt;
  logic sync_prev;
  logic sync_fall;
  logic standby;
  logic wake_pulse;
  logic cfg_restart;
  seq_state_e state;
  logic [18:0] tcnt;
  logic have_prev;
  logic polarity;
  logic signed [16:0] prev_s [chop_seq_pkg::NUM_CHANNELS];
  logic new_result;
  logic data_ready_flag_blip;
  logic [16:0] dly_len;
  logic [18:0] conv_len;
  logic conv_end;
  logic aligned;
  logic restart;
  logic halted;

  assign dly_len = dly_ticks(ctrl.chop_delay_code);
  assign conv_len = conv_ticks(ctrl.chop_enable, oversampling_ratio);
  assign halted = standby || device_reset_o;
  assign sync_fall = sync_prev && !sync_reset_n_i;
  assign conv_end = !halted && (state == st_conv) && mod_tick_o && (tcnt == conv_len - 19'd1);
  assign aligned = (state == st_conv) && (tcnt == 19'd0);
  // chop never checks alignment, continuous mode only acts when off the data-rate grid
  assign restart = wake_pulse || cfg_restart
    || (sync_fall && (ctrl.chop_enable || !aligned));
  assign conv_end_o = conv_end;
  assign polarity_rev_o = polarity;

  // sync pin low time decides between a sync and a full device reset
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_prev <= 1'b1;
      low_cnt <= '0;
      device_reset_o <= 1'b0;
    end else begin
      sync_prev <= sync_reset_n_i;
      if (sync_reset_n_i) begin
        low_cnt <= '0;
        device_reset_o <= 1'b0;
      end else if (low_cnt == ($bits(low_cnt))'(RESET_PULSE_CYCLES)) begin
        device_reset_o <= 1'b1;
      end else begin
        low_cnt <= low_cnt + 1'b1;
      end
    end
  end

  // modulator tick; the oscillator is off in standby so the tick stops too
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_cnt <= '0;
      mod_tick_o <= 1'b0;
    end else if (halted) begin
      div_cnt <= '0;
      mod_tick_o <= 1'b0;
    end else if (div_cnt == ($bits(div_cnt))'(MOD_DIV - 1)) begin
      div_cnt <= '0;
      mod_tick_o <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 1'b1;
      mod_tick_o <= 1'b0;
    end
  end

  // configuration registers; a held reset pin restores defaults, standby keeps them
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl <= '{chop_seq_pkg::PWR_RESET, chop_seq_pkg::DLY_CODE_RESET,
                chop_seq_pkg::CHOP_EN_RESET};
      oversampling_ratio <= chop_seq_pkg::OSR_RESET;
      cfg_restart <= 1'b0;
    end else if (device_reset_o) begin
      ctrl <= '{chop_seq_pkg::PWR_RESET, chop_seq_pkg::DLY_CODE_RESET,
                chop_seq_pkg::CHOP_EN_RESET};
      oversampling_ratio <= chop_seq_pkg::OSR_RESET;
      cfg_restart <= 1'b1;
    end else begin
      cfg_restart <= 1'b0;
      if (wr_i && addr_i == chop_seq_pkg::CTRL_OFFSET) begin
        ctrl.chop_enable <= wdata_i[chop_seq_pkg::CTRL_CHOP_EN_BIT];
        ctrl.chop_delay_code <= wdata_i[chop_seq_pkg::CTRL_DLY_LSB +: 4];
        ctrl.power_level_select <= wdata_i[chop_seq_pkg::CTRL_PWR_LSB +: 2];
        cfg_restart <= wdata_i[chop_seq_pkg::CTRL_CHOP_EN_BIT +: 5]
          != {ctrl.chop_delay_code, ctrl.chop_enable};
      end
      if (wr_i && addr_i == chop_seq_pkg::OSR_OFFSET) begin
        oversampling_ratio <= wdata_i[15:0];
        cfg_restart <= wdata_i[15:0] != oversampling_ratio;
      end
    end
  end

  assign power_level_o = ctrl.power_level_select;

  // standby and wakeup commands
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      standby <= 1'b0;
      wake_pulse <= 1'b0;
    end else begin
      wake_pulse <= 1'b0;
      if (device_reset_o) begin
        standby <= 1'b0;
      end else if (wr_i && addr_i == chop_seq_pkg::CMD_OFFSET) begin
        if (wdata_i[chop_seq_pkg::CMD_WAKEUP_BIT] && standby) begin
          standby <= 1'b0;
          wake_pulse <= 1'b1;
        end else if (wdata_i[chop_seq_pkg::CMD_STANDBY_BIT]) begin
          standby <= 1'b1;
        end
      end
    end
  end

  assign standby_o = standby;
  assign channel_enable_o = !halted;
  assign reference_enable_o = !standby;
  assign oscillator_enable_o = !standby;

  // conversion sequencer
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= st_halt;
      tcnt <= '0;
      polarity <= 1'b0;
      have_prev <= 1'b0;
      filter_reset_o <= 1'b0;
      new_result <= 1'b0;
    end else begin
      filter_reset_o <= 1'b0;
      new_result <= 1'b0;
      if (halted) begin
        state <= st_halt;
        tcnt <= '0;
        polarity <= 1'b0;
        have_prev <= 1'b0;
      end else if (restart || state == st_halt) begin
        state <= ctrl.chop_enable ? st_settle : st_conv;
        tcnt <= '0;
        polarity <= 1'b0;
        have_prev <= 1'b0;
        filter_reset_o <= 1'b1;
      end else if (mod_tick_o) begin
        case (state)
          st_settle: begin
            tcnt <= tcnt + 19'd1;
            if (tcnt == 19'(chop_seq_pkg::CHOP_SETTLE_EXTRA - 1)) begin
              tcnt <= '0;
              state <= st_delay;
            end
          end
          st_delay: begin
            tcnt <= tcnt + 19'd1;
            if (tcnt == 19'(dly_len) - 19'd1) begin
              tcnt <= '0;
              state <= st_conv;
            end
          end
          st_conv: begin
            tcnt <= tcnt + 19'd1;
            if (conv_end) begin
              tcnt <= '0;
              if (ctrl.chop_enable) begin
                have_prev <= 1'b1;
                new_result <= have_prev;
                polarity <= !polarity;
                filter_reset_o <= 1'b1;
                state <= st_delay;
              end else begin
                new_result <= 1'b1;
              end
            end
          end
          default: state <= st_halt;
        endcase
      end
    end
  end

  // results: chop pairs overlap, so every conversion after the first one following a restart yields a fresh mean
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_o <= '0;
      for (int i = 0; i < int'(chop_seq_pkg::NUM_CHANNELS); i++) begin
        prev_s[i] <= '0;
      end
    end else if (conv_end) begin
      for (int i = 0; i < int'(chop_seq_pkg::NUM_CHANNELS); i++) begin
        prev_s[i] <= oriented(conv_data_i.ch[i], polarity);
        if (!ctrl.chop_enable) begin
          result_o.ch[i] <= conv_data_i.ch[i];
        end else if (have_prev) begin
          result_o.ch[i] <= 16'((18'(prev_s[i]) + 18'(oriented(conv_data_i.ch[i], polarity)))
                                >>> 1);
        end
      end
    end
  end

  // data-ready: a back-to-back result first lifts the flag so a falling edge still shows
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_ready_n_o <= 1'b1;
      data_ready_flag_blip <= 1'b0;
    end else if (halted) begin
      data_ready_n_o <= 1'b1;
      data_ready_flag_blip <= 1'b0;
    end else if (new_result) begin
      data_ready_n_o <= !data_ready_n_o;
      data_ready_flag_blip <= !data_ready_n_o;
    end else if (data_ready_flag_blip) begin
      data_ready_n_o <= 1'b0;
      data_ready_flag_blip <= 1'b0;
    end else if (result_read_i) begin
      data_ready_n_o <= 1'b1;
    end
  end

  // register reads, one cycle late; unmapped addresses read zero
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= '0;
      if (rd_i) begin
        case (addr_i)
          chop_seq_pkg::CTRL_OFFSET: begin
            rdata_o[chop_seq_pkg::CTRL_CHOP_EN_BIT] <= ctrl.chop_enable;
            rdata_o[chop_seq_pkg::CTRL_DLY_LSB +: 4] <= ctrl.chop_delay_code;
            rdata_o[chop_seq_pkg::CTRL_PWR_LSB +: 2] <= ctrl.power_level_select;
          end
          chop_seq_pkg::OSR_OFFSET: rdata_o[15:0] <= oversampling_ratio;
          chop_seq_pkg::STATUS_OFFSET: begin
            rdata_o[chop_seq_pkg::STAT_STANDBY_BIT] <= standby;
            rdata_o[chop_seq_pkg::STAT_POLARITY_BIT] <= polarity;
            rdata_o[chop_seq_pkg::STAT_PENDING_BIT] <= !data_ready_n_o;
            rdata_o[chop_seq_pkg::STAT_SETTLING_BIT] <= ctrl.chop_enable && !have_prev;
          end
          default: rdata_o <= '0;
        endcase
      end
    end
  end

  // checking helpers: modulator ticks since the last result or restart
  logic [19:0] gap;
  logic first_after;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap <= '0;
      first_after <= 1'b1;
    end else if (halted || restart || state == st_halt) begin
      gap <= '0;
      first_after <= 1'b1;
    end else if (conv_end && (have_prev || !ctrl.chop_enable)) begin
      gap <= '0;
      first_after <= 1'b0;
    end else if (mod_tick_o) begin
      gap <= gap + 20'd1;
    end
  end

  logic [19:0] steady_len;
  logic [19:0] first_len;
  assign steady_len = ctrl.chop_enable ? 20'(dly_len) + 20'(conv_len) : 20'(conv_len);
  assign first_len = ctrl.chop_enable
    ? 20'(20'd2 * steady_len + 20'(chop_seq_pkg::CHOP_SETTLE_EXTRA)) : 20'(conv_len);

  sequence s_chop_swap;
    conv_end && ctrl.chop_enable && !restart;
  endsequence

  sequence s_chop_sync;
    sync_fall && ctrl.chop_enable && !halted;
  endsequence

  a_swap_polarity: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    s_chop_swap |=> $changed(polarity) && filter_reset_o)
    else $error("polarity not swapped with filter reset");

  a_first_result_len: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    conv_end && first_after && (have_prev || !ctrl.chop_enable) && !restart
      |-> gap + 20'd1 == first_len)
    else $error("first result period wrong");

  a_steady_result_len: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    conv_end && !first_after && !restart |-> gap + 20'd1 == steady_len)
    else $error("steady result period wrong");

  a_flag_falls: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    new_result && !halted |-> ##[1:2] !data_ready_n_o)
    else $error("data-ready did not fall after result");

  a_settling_quiet: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    s_chop_swap ##0 !have_prev |=> !new_result && $stable(result_o))
    else $error("settling conversion produced a result");

  a_chop_sync_restart: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    s_chop_sync |=> state == st_settle && filter_reset_o && tcnt == 19'd0)
    else $error("chop sync edge did not restart");

  a_aligned_no_action: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    sync_fall && aligned && !ctrl.chop_enable && !halted && !wake_pulse && !cfg_restart
      |=> !filter_reset_o)
    else $error("aligned sync edge caused a restart");

  a_long_low_reset: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !sync_reset_n_i && low_cnt == ($bits(low_cnt))'(RESET_PULSE_CYCLES)
      |=> device_reset_o ##1 (device_reset_o || sync_reset_n_i))
    else $error("long low sync did not hold reset");

  a_standby_power: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    standby_o |-> (!channel_enable_o && !reference_enable_o && !oscillator_enable_o)
      ##1 (!standby_o || (data_ready_n_o && !mod_tick_o)))
    else $error("standby left circuits powered");

  a_wakeup_resume: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    wr_i && addr_i == chop_seq_pkg::CMD_OFFSET && wdata_i[chop_seq_pkg::CMD_WAKEUP_BIT]
      && standby_o && !device_reset_o |=> !standby_o ##1 filter_reset_o)
    else $error("wakeup did not resume conversion");
endmodule
